// File: ifb_pkg.sv
// constants shared by the interrupt flag and enable bank
package ifb_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 8;
  localparam int BUS_W    = 32;
  localparam int NUM_REGS = 9;
  localparam int NUM_SRC  = 11;
  localparam int VEC_W    = 4;
  localparam int NUM_TMR  = 4;
  localparam int NUM_GRP  = 5;
  localparam int EVT_W    = 3;

  // ----------------------------------------------------------------
  // register indices, byte offset is four times the index
  // ----------------------------------------------------------------
  localparam int IDX_EDGE = 0;
  localparam int IDX_C0   = 1;
  localparam int IDX_C1   = 2;
  localparam int IDX_C2   = 3;
  localparam int IDX_TIMER0_MATCH_IRQ = 4;
  localparam int IDX_TIMER3_MATCH_IRQ = 7;
  localparam int IDX_MISC_PERIPH_IRQ = 8;

  localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_EVT_CLR  = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_EVT_EN   = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_VEC_STAT = 8'h30;

  // implemented bits per register, the rest read zero
  localparam logic [DATA_W-1:0] REG_MASK [0:NUM_REGS-1] = '{
    8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'h33, 8'h33, 8'h33, 8'h77, 8'hFF};
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EDGE0_LSB   = 0;
  localparam int EDGE1_LSB   = 2;
  localparam int C0_GLOBAL   = 0;
  localparam int C0_GRP0_F   = 6;
  localparam int C2_PIN1_F   = 7;
  localparam int C2_TB0_F    = 5;
  localparam int C2_TB1_F    = 6;
  localparam int C2_CONV_F   = 4;
  localparam int C0_CMP_F    = 5;
  localparam int C0_PIN0_F   = 4;
  localparam int C1_GRP1_F   = 4;
  localparam int MFI_P_F     = 4;
  localparam int MFI_A_F     = 5;
  localparam int MFI_B_F     = 6;
  localparam int MISC_PERIPH_IRQ_LV_F   = 4;
  localparam int MISC_PERIPH_IRQ_EE_F   = 5;
  localparam int MISC_PERIPH_IRQ_SIM_F  = 6;
  localparam int MISC_PERIPH_IRQ_SER_F  = 7;
  localparam int FLAG_LSB    = 4;
  localparam int FLAG_HALF   = 4;

  // ----------------------------------------------------------------
  // vector sources in priority order, index 0 wins
  // ----------------------------------------------------------------
  localparam int SRC_REG  [0:NUM_SRC-1] = '{1, 1, 1, 2, 2, 2, 2,
                                            3, 3, 3, 3};
  localparam int SRC_FBIT [0:NUM_SRC-1] = '{4, 5, 6, 4, 5, 6, 7,
                                            7, 5, 6, 4};
  localparam int SRC_EBIT [0:NUM_SRC-1] = '{1, 2, 3, 0, 1, 2, 3,
                                            3, 1, 2, 0};

  // ----------------------------------------------------------------
  // edge select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ----------------------------------------------------------------
  // event status bits
  // ----------------------------------------------------------------
  localparam int EVT_TAKEN   = 0;
  localparam int EVT_BLOCKED = 1;
  localparam int EVT_WAKE    = 2;

  typedef enum logic {BUS_IDLE, BUS_DONE} ifb_bus_state_type;

endpackage : ifb_pkg

// File: ifb_pin_edge.sv
// edge detector for one external interrupt pin
module ifb_pin_edge
  import ifb_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // pin and selection
  input  wire logic       pin_level,
  input  wire logic [1:0] edge_sel,
  // detected edge
  output logic            edge_evt
);

  logic prev_r;
  logic armed_r;
  logic rise;
  logic fall;

  // ----------------------------------------------------------------
  // history
  // ----------------------------------------------------------------
  // armed_r hides the first sample so reset never looks like an edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_r  <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      prev_r  <= pin_level;
      armed_r <= 1'b1;
    end
  end

  assign rise = armed_r & pin_level & ~prev_r;
  assign fall = armed_r & ~pin_level & prev_r;

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  always_comb begin
    case (edge_sel)
      EDGE_OFF:  edge_evt = 1'b0;
      EDGE_RISE: edge_evt = rise;
      EDGE_FALL: edge_evt = fall;
      EDGE_BOTH: edge_evt = rise | fall;
      default:   edge_evt = 1'b0;
    endcase
  end

endmodule : ifb_pin_edge

// File: ifb_top.sv
// interrupt request flag and enable register bank with vector dispatch
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
module ifb_top
  import ifb_pkg::*;
(
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]  avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [BUS_W-1:0]   avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic [BUS_W-1:0]        avs_readdata,
  output logic                    avs_waitrequest,
  // external pins
  input  wire logic               pin0_level,
  input  wire logic               pin1_level,
  // internal event pulses
  input  wire logic               comparator_evt,
  input  wire logic [NUM_TMR-1:0] timer_period_evt,
  input  wire logic [NUM_TMR-1:0] timer_cmpa_evt,
  input  wire logic               timer3_cmpb_evt,
  input  wire logic [1:0]         timebase_evt,
  input  wire logic               converter_done_evt,
  input  wire logic               low_voltage_evt,
  input  wire logic               eeprom_evt,
  input  wire logic               sim_evt,
  input  wire logic               serial_port_evt,
  // processor core
  input  wire logic               stack_full,
  input  wire logic               core_irq_ack,
  output logic                    core_irq_req,
  output logic [VEC_W-1:0]        core_vector,
  output logic                    wake_req,
  // bank interrupt
  output logic                    irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ifb_bus_state_type bus_state_r;
  logic [DATA_W-1:0] regs_r   [0:NUM_REGS-1];
  logic [DATA_W-1:0] regs_nxt [0:NUM_REGS-1];
  logic [DATA_W-1:0] hw_set   [0:NUM_REGS-1];
  logic [DATA_W-1:0] hw_clr   [0:NUM_REGS-1];
  logic [NUM_REGS-1:0] wr_sel;
  logic [EVT_W-1:0]  evt_stat_r;
  logic [EVT_W-1:0]  evt_stat_nxt;
  logic [EVT_W-1:0]  evt_en_r;
  logic [EVT_W-1:0]  evt_en_nxt;
  logic [EVT_W-1:0]  evt_set;
  logic [EVT_W-1:0]  evt_clr;
  logic [NUM_SRC-1:0] src_pend;
  logic [NUM_GRP-1:0] grp_any;
  logic [NUM_GRP-1:0] grp_any_r;
  logic [NUM_GRP-1:0] grp_rise;
  logic [1:0]        pin_evt;
  logic [1:0]        pin_level;
  logic [VEC_W-1:0]  win_idx;
  logic [BUS_W-1:0]  readdata_r;
  logic              wait_r;
  logic              req_r;
  logic [VEC_W-1:0]  vec_r;
  logic              wake_r;
  logic              irq_r;
  logic              bus_req;
  logic              wr_fire;
  logic              lane0;
  logic [DATA_W-1:0] wdata;
  logic [5:0]        word_idx;
  logic              hit_bank;
  logic              hit_stat;
  logic              hit_clr;
  logic              hit_en;
  logic              hit_vec;
  logic [DATA_W-1:0] rd_byte;
  logic              global_en;
  logic              any_pend;
  logic              take;
  logic              ack_fire;
  logic              any_flag_set;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign bus_req  = avs_read | avs_write;
  assign lane0    = avs_byteenable[0];
  assign wdata    = avs_writedata[DATA_W-1:0];
  assign wr_fire  = avs_write & ~wait_r & lane0;
  assign word_idx = avs_address[ADDR_W-1:2];
  assign hit_bank = (word_idx < 6'(NUM_REGS));
  assign hit_stat = (avs_address[ADDR_W-1:2] == OFS_EVT_STAT[ADDR_W-1:2]);
  assign hit_clr  = (avs_address[ADDR_W-1:2] == OFS_EVT_CLR[ADDR_W-1:2]);
  assign hit_en   = (avs_address[ADDR_W-1:2] == OFS_EVT_EN[ADDR_W-1:2]);
  assign hit_vec  = (avs_address[ADDR_W-1:2] == OFS_VEC_STAT[ADDR_W-1:2]);

  // unmapped addresses read zero and swallow writes
  assign rd_byte =
    hit_bank ? (regs_r[word_idx[3:0]] & REG_MASK[word_idx[3:0]]) :
    hit_stat ? DATA_W'(evt_stat_r) :
    hit_en   ? DATA_W'(evt_en_r) :
    hit_vec  ? DATA_W'({req_r, stack_full, 2'h0, vec_r}) :
               8'h00;

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, then the answer
  // ----------------------------------------------------------------
  // readdata is caught at the take and stands until the next request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_state_r <= BUS_IDLE;
      wait_r      <= 1'b1;
      readdata_r  <= 32'h0000_0000;
    end else begin
      case (bus_state_r)
        BUS_IDLE: begin
          if (bus_req) begin
            bus_state_r <= BUS_DONE;
            wait_r      <= 1'b0;
            readdata_r  <= BUS_W'(rd_byte);
          end
        end
        BUS_DONE: begin
          bus_state_r <= BUS_IDLE;
          wait_r      <= 1'b1;
        end
        default: begin
          bus_state_r <= BUS_IDLE;
          wait_r      <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // external pins
  // ----------------------------------------------------------------
  // pins are taken as synchronous, so no extra sampling stage here
  assign pin_level = {pin1_level, pin0_level};

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_pin
      ifb_pin_edge u_edge (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .pin_level (pin_level[gp]),
        .edge_sel  (regs_r[IDX_EDGE][EDGE0_LSB + 2*gp +: 2]),
        .edge_evt  (pin_evt[gp])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // group summaries
  // ----------------------------------------------------------------
  // a group flag rises when the group goes from no enabled sub request to one, so clearing
  // it by service does not retrigger while the sub flag is still up
  genvar gg;
  generate
    for (gg = 0; gg < NUM_GRP; gg++) begin : g_grp
      assign grp_any[gg] =
        |(regs_r[IDX_TIMER0_MATCH_IRQ+gg][DATA_W-1:FLAG_LSB]
          & regs_r[IDX_TIMER0_MATCH_IRQ+gg][FLAG_HALF-1:0]);
    end
  endgenerate

  assign grp_rise = grp_any & ~grp_any_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      grp_any_r <= '0;
    end else begin
      grp_any_r <= grp_any;
    end
  end

  // ----------------------------------------------------------------
  // hardware set and clear terms
  // ----------------------------------------------------------------
  always_comb begin
    for (int r = 0; r < NUM_REGS; r++) begin
      hw_set[r] = '0;
      hw_clr[r] = '0;
    end
    hw_set[IDX_C0][C0_PIN0_F]  = pin_evt[0];
    hw_set[IDX_C0][C0_CMP_F]   = comparator_evt;
    hw_set[IDX_C0][C0_GRP0_F]  = grp_rise[0];
    for (int g = 1; g < NUM_GRP; g++) begin
      hw_set[IDX_C1][C1_GRP1_F+g-1] = grp_rise[g];
    end
    hw_set[IDX_C2][C2_PIN1_F]  = pin_evt[1];
    hw_set[IDX_C2][C2_TB0_F]   = timebase_evt[0];
    hw_set[IDX_C2][C2_TB1_F]   = timebase_evt[1];
    hw_set[IDX_C2][C2_CONV_F]  = converter_done_evt;
    for (int t = 0; t < NUM_TMR; t++) begin
      hw_set[IDX_TIMER0_MATCH_IRQ+t][MFI_P_F] = timer_period_evt[t];
      hw_set[IDX_TIMER0_MATCH_IRQ+t][MFI_A_F] = timer_cmpa_evt[t];
    end
    hw_set[IDX_TIMER3_MATCH_IRQ][MFI_B_F]    = timer3_cmpb_evt;
    hw_set[IDX_MISC_PERIPH_IRQ][MISC_PERIPH_IRQ_LV_F]  = low_voltage_evt;
    hw_set[IDX_MISC_PERIPH_IRQ][MISC_PERIPH_IRQ_EE_F]  = eeprom_evt;
    hw_set[IDX_MISC_PERIPH_IRQ][MISC_PERIPH_IRQ_SIM_F] = sim_evt;
    hw_set[IDX_MISC_PERIPH_IRQ][MISC_PERIPH_IRQ_SER_F] = serial_port_evt;
    // service clears the taken flag and the global enable
    if (ack_fire) begin
      for (int s = 0; s < NUM_SRC; s++) begin
        if (vec_r == VEC_W'(s)) begin
          hw_clr[SRC_REG[s]][SRC_FBIT[s]] = 1'b1;
        end
      end
      hw_clr[IDX_C0][C0_GLOBAL] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  genvar gr;
  generate
    for (gr = 0; gr < NUM_REGS; gr++) begin : g_reg
      assign wr_sel[gr] = wr_fire & hit_bank
                          & (word_idx[3:0] == 4'(gr));
      // a hardware set wins over a write or a service clear
      assign regs_nxt[gr] =
        (((wr_sel[gr] ? wdata : regs_r[gr]) & ~hw_clr[gr])
         | hw_set[gr]) & REG_MASK[gr];

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          regs_r[gr] <= REG_RESET;
        end else begin
          regs_r[gr] <= regs_nxt[gr];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // pending sources and priority
  // ----------------------------------------------------------------
  genvar gs;
  generate
    for (gs = 0; gs < NUM_SRC; gs++) begin : g_src
      assign src_pend[gs] = regs_r[SRC_REG[gs]][SRC_FBIT[gs]]
                            & regs_r[SRC_REG[gs]][SRC_EBIT[gs]];
    end
  endgenerate

  // scanning downwards leaves the lowest pending index as the winner
  always_comb begin
    win_idx = '0;
    for (int s = NUM_SRC - 1; s >= 0; s--) begin
      if (src_pend[s]) begin
        win_idx = VEC_W'(s);
      end
    end
  end

  assign global_en = regs_r[IDX_C0][C0_GLOBAL];
  assign any_pend  = |src_pend;
  assign ack_fire  = req_r & core_irq_ack;
  // the request is re-evaluated every cycle, so a full stack or a
  // cleared enable withdraws it at the next clock edge
  assign take = global_en & any_pend & ~stack_full & ~ack_fire;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      req_r <= 1'b0;
      vec_r <= '0;
    end else begin
      req_r <= take;
      vec_r <= win_idx;
    end
  end

  // ----------------------------------------------------------------
  // wake and event status
  // ----------------------------------------------------------------
  // only fresh hardware sets wake the core, software writes do so only by making a group flag rise
  always_comb begin
    any_flag_set = 1'b0;
    for (int r = 0; r < NUM_REGS; r++) begin
      any_flag_set = any_flag_set
                     | (|(hw_set[r] & ~regs_r[r] & REG_MASK[r]));
    end
  end

  assign evt_set[EVT_TAKEN]   = ack_fire;
  assign evt_set[EVT_BLOCKED] = global_en & any_pend & stack_full;
  assign evt_set[EVT_WAKE]    = any_flag_set;
  assign evt_clr      = (wr_fire & hit_clr) ? wdata[EVT_W-1:0] : '0;
  assign evt_stat_nxt = (evt_stat_r & ~evt_clr) | evt_set;
  assign evt_en_nxt   = (wr_fire & hit_en) ? wdata[EVT_W-1:0] : evt_en_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      evt_stat_r <= '0;
      evt_en_r   <= '0;
      wake_r     <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      evt_stat_r <= evt_stat_nxt;
      evt_en_r   <= evt_en_nxt;
      wake_r     <= any_flag_set;
      // irq uses next values so it never lags the status it reports
      irq_r      <= |(evt_stat_nxt & evt_en_nxt);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata    = readdata_r;
  assign avs_waitrequest = wait_r;
  assign core_irq_req    = req_r;
  assign core_vector     = vec_r;
  assign wake_req        = wake_r;
  assign irq             = irq_r;

endmodule : ifb_top

// File: ifb_top_sva.sv
// concurrent checks on the bus and core ports of the interrupt bank
module ifb_top_sva
  import ifb_pkg::*;
(
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  // register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [BUS_W-1:0]  avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [BUS_W-1:0]  avs_readdata,
  input wire logic              avs_waitrequest,
  // processor core
  input wire logic              stack_full,
  input wire logic              core_irq_ack,
  input wire logic              core_irq_req,
  input wire logic              wake_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // answer cycle of a bus access
  wire rd_done = avs_read && !avs_waitrequest;
  wire wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];

  // ------------------------------------------------------------
  // bus timing and read values
  // ------------------------------------------------------------
  chk_wait_answer: assert property (
    $rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("bus answer not one cycle after request");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_unmapped_zero: assert property (
    rd_done && avs_address >= 8'h34 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_edge_unused: assert property (
    rd_done && avs_address == 8'h00 |-> avs_readdata[7:4] == 4'h0)
    else $error("edge register upper bits not zero");
  chk_ctrl0_unused: assert property (
    rd_done && avs_address == 8'h04 |-> !avs_readdata[7])
    else $error("control 0 bit 7 not zero");

  // ------------------------------------------------------------
  // request gating towards the core
  // ------------------------------------------------------------
  // req is registered after the write lands, so allow the pipeline
  chk_global_off: assert property (
    wr_done && avs_address == 8'h04 && !avs_writedata[0]
    |-> ##3 !core_irq_req)
    else $error("request with global enable cleared");
  chk_stack_block: assert property (stack_full |=> !core_irq_req)
    else $error("request while return stack full");
  chk_ack_drop: assert property (
    core_irq_req && core_irq_ack |=> !core_irq_req)
    else $error("request kept after vector taken");

  cov_taken: cover property (core_irq_req && core_irq_ack);
  cov_blocked: cover property (stack_full ##1 !core_irq_req);
  cov_wake: cover property (wake_req);
endmodule : ifb_top_sva

bind ifb_top ifb_top_sva chk_u (
  .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .stack_full(stack_full), .core_irq_ack(core_irq_ack),
  .core_irq_req(core_irq_req), .wake_req(wake_req)
);

// File: ifb_core_model.sv
// behavioural processor core that accepts vector requests
module ifb_core_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // bench controls
  input wire logic stack_hold,
  input wire logic slow,
  // bank side
  input wire logic core_irq_req,
  output logic     core_irq_ack,
  output logic     stack_full
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_r;

  // a full return stack holds off every vector until popped
  assign stack_full = stack_hold;

  // slow mode lets the request stand a few cycles before the take
  always_ff @(posedge sys_clk) begin
    if (rst || core_irq_ack || !core_irq_req) begin
      core_irq_ack <= 1'b0;
      wait_r       <= 2'h0;
    end else if (!slow || wait_r == 2'h3) begin
      core_irq_ack <= 1'b1;
    end else begin
      wait_r <= wait_r + 2'h1;
    end
  end
endmodule : ifb_core_model

// File: ifb_top_bench.sv
// self-checking bench for the interrupt flag and enable bank
module ifb_top_bench
  import ifb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic               sys_clk = 1'b0;
  logic               rst = 1'b1;
  logic [ADDR_W-1:0]  avs_address = 8'h00;
  logic               avs_read = 1'b0, avs_write = 1'b0;
  logic [BUS_W-1:0]   avs_writedata = 32'h0, avs_readdata;
  logic [3:0]         avs_byteenable = 4'h0;
  logic               avs_waitrequest, pin0_level = 1'b0, pin1_level = 1'b0;
  logic               comparator_evt = 1'b0, timer3_cmpb_evt = 1'b0;
  logic [NUM_TMR-1:0] timer_period_evt = 4'h0, timer_cmpa_evt = 4'h0;
  logic [1:0]         timebase_evt = 2'h0;
  logic               converter_done_evt = 1'b0, low_voltage_evt = 1'b0;
  logic               eeprom_evt = 1'b0, sim_evt = 1'b0;
  logic               serial_port_evt = 1'b0, stack_hold = 1'b0, slow = 1'b0;
  logic               stack_full, core_irq_ack, core_irq_req, wake_req, irq;
  logic [VEC_W-1:0]   core_vector;
  logic [VEC_W-1:0]   vec_q[$];
  logic [BUS_W-1:0]   exp_q[$], msk_q[$];
  logic [DATA_W-1:0]  rnd;
  int                 fail_count = 0, compares = 0, ack_count = 0;

  always #25 sys_clk = ~sys_clk;

  ifb_top dut_u (
    .sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin0_level,
    .pin1_level, .comparator_evt, .timer_period_evt, .timer_cmpa_evt,
    .timer3_cmpb_evt, .timebase_evt, .converter_done_evt, .low_voltage_evt,
    .eeprom_evt, .sim_evt, .serial_port_evt, .stack_full, .core_irq_ack,
    .core_irq_req, .core_vector, .wake_req, .irq
  );
  ifb_core_model core_u (
    .sys_clk, .rst, .stack_hold, .slow, .core_irq_req, .core_irq_ack,
    .stack_full
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic fail_msg(input string msg);
    fail_count++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : fail_msg

  task automatic report_and_stop();
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) fail_msg("output level");
  endtask : check_bit

  // request held until waitrequest is seen low at a rising edge
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d,
                           input logic [3:0] be = 4'hF);
    @(posedge sys_clk);
    avs_address    <= a;
    avs_writedata  <= {24'($urandom), d};
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, input logic [31:0] e,
                          input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
  endtask : bus_read

  task automatic pin_edge(input int p, input logic lvl, input logic hit);
    logic [31:0] ex;
    ex = p ? 32'h80 : 32'h10;
    bus_write(p ? 8'h0C : 8'h04, 8'h00);
    if (p) pin1_level <= lvl;
    else pin0_level <= lvl;
    repeat (4) @(posedge sys_clk);
    bus_read(p ? 8'h0C : 8'h04, hit ? ex : 32'h0, ex);
  endtask : pin_edge

  task automatic wait_acks(input int n);
    for (int k = 0; k < 40 && ack_count < n; k++) @(posedge sys_clk);
    @(posedge sys_clk);
    compares++;
    if (ack_count != n) fail_msg("vector not taken in time");
  endtask : wait_acks

  // ------------------------------------------------------------
  // result monitor: oldest note against each answer
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      compares++;
      if ((avs_readdata & msk_q.pop_front()) !== exp_q.pop_front())
        fail_msg("register read data");
    end
    if (core_irq_ack === 1'b1 && core_irq_req === 1'b1) begin
      ack_count++;
      compares++;
      if (core_vector !== vec_q.pop_front()) fail_msg("vector");
    end
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    report_and_stop();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(2113));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    bus_write(8'h0C, 8'hFF, 4'hE);
    for (int i = 0; i < 10; i++)
      bus_read(8'(i * 4), 32'h0, 32'hFFFFFFFF);
    // a full stack keeps random enables from starting vectors here
    stack_hold <= 1'b1;
    for (int i = 0; i < NUM_REGS; i++) begin
      rnd = 8'($urandom);
      bus_write(8'(i * 4), rnd);
      bus_read(8'(i * 4), {24'h0, rnd & REG_MASK[i]}, 32'hFF);
      bus_write(8'(i * 4), 8'h00);
    end
    bus_write(8'h04, 8'h00);
    bus_write(8'h08, 8'h00);
    stack_hold <= 1'b0;
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 4; c++) begin
        bus_write(8'h00, 8'(c << (2 * p)));
        pin_edge(p, 1'b1, c[0]);
        pin_edge(p, 1'b0, c[1]);
      end
    bus_write(8'h28, 8'h07);
    bus_write(8'h2C, 8'h01);
    bus_write(8'h0C, 8'h03);
    bus_write(8'h04, 8'h04);
    comparator_evt     <= 1'b1;
    timebase_evt       <= 2'h3;
    converter_done_evt <= 1'b1;
    @(posedge sys_clk);
    comparator_evt     <= 1'b0;
    timebase_evt       <= 2'h0;
    converter_done_evt <= 1'b0;
    repeat (3) @(posedge sys_clk);
    bus_read(8'h30, 32'h0, 32'h80);
    bus_read(8'h04, 32'h24, 32'hFF);
    vec_q = '{4'h1, 4'h8, 4'hA};
    bus_write(8'h04, 8'h25);
    wait_acks(1);
    bus_write(8'h04, 8'h05);
    wait_acks(2);
    bus_write(8'h04, 8'h05);
    wait_acks(3);
    bus_read(8'h04, 32'h04, 32'hFF);
    bus_read(8'h0C, 32'h43, 32'hFF);
    check_bit(irq, 1'b1);
    bus_read(8'h24, 32'h01, 32'h01);
    bus_write(8'h28, 8'h07);
    repeat (2) @(posedge sys_clk);
    check_bit(irq, 1'b0);
    bus_write(8'h24, 8'hFF);
    bus_read(8'h24, 32'h00, 32'h03);
    bus_write(8'h3C, 8'hFF);
    bus_read(8'h3C, 32'h00, 32'hFFFFFFFF);
    comparator_evt <= 1'b1;
    @(posedge sys_clk);
    comparator_evt <= 1'b0;
    @(posedge sys_clk);
    check_bit(wake_req, 1'b1);
    @(posedge sys_clk);
    check_bit(wake_req, 1'b0);
    @(posedge sys_clk);
    bus_read(8'h04, 32'h24, 32'hFF);
    stack_hold <= 1'b1;
    slow       <= 1'b1;
    bus_write(8'h04, 8'h25);
    repeat (6) @(posedge sys_clk);
    bus_read(8'h30, 32'h40, 32'hC0);
    bus_read(8'h24, 32'h02, 32'h02);
    vec_q.push_back(4'h1);
    stack_hold <= 1'b0;
    wait_acks(4);
    bus_write(8'h2C, 8'h00);
    repeat (2) @(posedge sys_clk);
    check_bit(irq, 1'b0);
    bus_write(8'h1C, 8'h04);
    bus_write(8'h20, 8'h01);
    {timer_period_evt, timer_cmpa_evt} <= 8'hFF;
    {timer3_cmpb_evt, low_voltage_evt, eeprom_evt} <= 3'h7;
    {sim_evt, serial_port_evt} <= 2'h3;
    @(posedge sys_clk);
    {timer_period_evt, timer_cmpa_evt} <= 8'h00;
    {timer3_cmpb_evt, low_voltage_evt, eeprom_evt} <= 3'h0;
    {sim_evt, serial_port_evt} <= 2'h0;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 3; i++)
      bus_read(8'h10 + 8'(i * 4), 32'h30, 32'hFF);
    bus_read(8'h1C, 32'h74, 32'hFF);
    bus_read(8'h20, 32'hF1, 32'hFF);
    bus_read(8'h08, 32'hC0, 32'hFF);
    report_and_stop();
  end
endmodule : ifb_top_bench
